// [cst_prim.sv]
`timescale 1ns/1ps

package cst_pkg;

  // ==========================================================================
  // Register map (byte addresses, one aligned word each)
  localparam int unsigned ADDR_W      = 6;
  localparam logic [5:0]  OFS_CTRL    = 6'h00;
  localparam logic [5:0]  OFS_PERIOD  = 6'h04;
  localparam logic [5:0]  OFS_COUNT   = 6'h08;
  localparam logic [5:0]  OFS_STATUS  = 6'h0C;
  localparam logic [5:0]  OFS_MASK    = 6'h10;

  // ==========================================================================
  // Control field positions
  localparam int unsigned CTRL_W        = 5;
  localparam int unsigned CTRL_CASCADE  = 0;
  localparam int unsigned CTRL_LOW_CS   = 1;
  localparam int unsigned CTRL_HIGH_CS  = 2;
  localparam int unsigned CTRL_LOW_EN   = 3;
  localparam int unsigned CTRL_HIGH_EN  = 4;

  // Status and mask field positions
  localparam int unsigned STAT_W    = 2;
  localparam int unsigned STAT_LOW  = 0;
  localparam int unsigned STAT_HIGH = 1;

  // Byte layout of period and count words
  localparam int unsigned BYTE_W = 8;
  localparam int unsigned LO_LSB = 0;
  localparam int unsigned HI_LSB = 8;

  // ==========================================================================
  // Reset values
  localparam logic [4:0]  CTRL_RST   = 5'h00;
  localparam logic [7:0]  PRD_RST    = 8'hFF;
  localparam logic [7:0]  CNT_RST    = 8'h00;
  localparam logic [1:0]  STAT_RST   = 2'h0;
  localparam logic [1:0]  MASK_RST   = 2'h0;

  // ==========================================================================
  // Timing: one instruction cycle is four clocks, two pin samples per cycle
  localparam int unsigned INSTR_DIV = 4;
  localparam int unsigned DIV_W     = $clog2(INSTR_DIV);
  localparam logic [1:0]  DIV_LAST  = 2'(INSTR_DIV - 1);
  localparam logic [1:0]  DIV_STEP  = 2'h1;
  localparam int unsigned PHASE_BIT = 0;

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ==========================================================================
  // Bus state machines (W_ADDR and W_DATA each one bit from W_IDLE and from W_RESP)
  typedef enum logic [1:0] {
    W_IDLE = 2'h0,
    W_ADDR = 2'h1,
    W_RESP = 2'h3,
    W_DATA = 2'h2
  } cst_wr_e;

  typedef enum logic {
    R_IDLE = 1'h0,
    R_DATA = 1'h1
  } cst_rd_e;

endpackage

// ============================================================================
// External timer clock: synchroniser, phase sampling, falling edge pulse
module cst_ext_clk_sync (
  // Clock and reset
  input  wire logic aclk,
  input  wire logic aresetn,
  // Pin and sampling phase
  input  wire logic pin,
  input  wire logic sample_en,
  // Falling edge seen, one cycle
  output logic      fall
);

  typedef struct packed {
    logic s1;
    logic s2;
    logic smp;
    logic fall;
  } cst_sync_s;

  cst_sync_s q;
  cst_sync_s d;

  // Next state: s1 is read only by s2; sampling happens on phase strobes
  always_comb begin
    d      = q;
    d.s1   = pin;
    d.s2   = q.s1;
    d.fall = 1'b0;
    if (sample_en) begin
      d.smp  = q.s2;
      d.fall = q.smp & ~q.s2;
    end
  end

  // Idle level high so a pin held high at reset gives no false edge
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= '{s1: 1'b1, s2: 1'b1, smp: 1'b1, fall: 1'b0};
    end else begin
      q <= d;
    end
  end

  assign fall = q.fall;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_edge_from_sample: assert property (q.fall |-> $past(q.smp) && !q.smp)
    else $error("edge pulse without a high to low sample");

endmodule // cst_ext_clk_sync

// [cst_timer.sv]
`timescale 1ns/1ps

module cst_timer (
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite write address
  input  wire logic [5:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [5:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Timer pin and interrupt
  input  wire logic        shared_ext_timer_clock,
  output logic             irq
);

  // ==========================================================================
  // State
  typedef struct packed {
    cst_pkg::cst_wr_e wst;
    cst_pkg::cst_rd_e rst;
    logic             awready;
    logic             wready;
    logic             bvalid;
    logic [1:0]       bresp;
    logic             arready;
    logic             rvalid;
    logic [1:0]       rresp;
    logic [31:0]      rdata;
    logic [5:0]       awaddr;
    logic [31:0]      wdata;
    logic [3:0]       wstrb;
    logic [4:0]       ctrl;
    logic [7:0]       low_period_byte;
    logic [7:0]       high_period_byte;
    logic [7:0]       low_count_byte;
    logic [7:0]       high_count_byte;
    logic [1:0]       status;
    logic [1:0]       mask;
    logic [1:0]       div;
    logic             irq;
  } cst_state_s;

  cst_state_s  q;
  cst_state_s  d;

  logic        ext_fall;
  logic        tick_icyc;
  logic        tick_lo;
  logic        tick_hi;
  logic        cascade_mode_select;
  logic        low_clock_source_select;
  logic        high_clock_source_select;
  logic        low_counter_enable;
  logic        high_counter_enable;
  logic        do_wr;
  logic [5:0]  wa;
  logic [31:0] wd;
  logic [3:0]  ws;
  logic [1:0]  set_flag;
  logic [1:0]  clr_flag;
  logic [15:0] count16;
  logic [15:0] period16;

  // ==========================================================================
  // External clock pin, sampled on both phases of each instruction cycle
  cst_ext_clk_sync u_sync (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .pin       (shared_ext_timer_clock),
    .sample_en (q.div[cst_pkg::PHASE_BIT]),
    .fall      (ext_fall)
  );

  // Control decode and timer clock selection
  always_comb begin
    cascade_mode_select      = q.ctrl[cst_pkg::CTRL_CASCADE];
    low_clock_source_select  = q.ctrl[cst_pkg::CTRL_LOW_CS];
    high_clock_source_select = q.ctrl[cst_pkg::CTRL_HIGH_CS];
    low_counter_enable       = q.ctrl[cst_pkg::CTRL_LOW_EN];
    high_counter_enable      = q.ctrl[cst_pkg::CTRL_HIGH_EN];
    tick_icyc = (q.div == cst_pkg::DIV_LAST);
    tick_lo   = low_clock_source_select ? ext_fall : tick_icyc;
    tick_hi   = high_clock_source_select ? ext_fall : tick_icyc;
    count16   = {q.high_count_byte, q.low_count_byte};
    period16  = {q.high_period_byte, q.low_period_byte};
  end

  // ==========================================================================
  // Next state: bus slave, counters, flags
  always_comb begin
    d        = q;
    do_wr    = 1'b0;
    wa       = q.awaddr;
    wd       = q.wdata;
    ws       = q.wstrb;
    set_flag = '0;
    clr_flag = '0;
    d.div    = q.div + cst_pkg::DIV_STEP;

    // Write channel: address and data may arrive in either order
    case (q.wst)
      cst_pkg::W_IDLE: begin
        if (s_axi_awvalid && q.awready && s_axi_wvalid && q.wready) begin
          wa    = s_axi_awaddr;
          wd    = s_axi_wdata;
          ws    = s_axi_wstrb;
          do_wr = 1'b1;
          d.wst = cst_pkg::W_RESP;
        end else if (s_axi_awvalid && q.awready) begin
          d.awaddr = s_axi_awaddr;
          d.wst    = cst_pkg::W_ADDR;
        end else if (s_axi_wvalid && q.wready) begin
          d.wdata = s_axi_wdata;
          d.wstrb = s_axi_wstrb;
          d.wst   = cst_pkg::W_DATA;
        end
      end
      cst_pkg::W_ADDR: begin
        if (s_axi_wvalid && q.wready) begin
          wd    = s_axi_wdata;
          ws    = s_axi_wstrb;
          do_wr = 1'b1;
          d.wst = cst_pkg::W_RESP;
        end
      end
      cst_pkg::W_DATA: begin
        if (s_axi_awvalid && q.awready) begin
          wa    = s_axi_awaddr;
          do_wr = 1'b1;
          d.wst = cst_pkg::W_RESP;
        end
      end
      cst_pkg::W_RESP: begin
        if (s_axi_bready) begin
          d.wst = cst_pkg::W_IDLE;
        end
      end
      default: begin
        d.wst = cst_pkg::W_IDLE;
      end
    endcase

    // Register write; count is read-only so software cannot race the timer
    if (do_wr) begin
      d.bresp = cst_pkg::RESP_OKAY;
      case (wa)
        cst_pkg::OFS_CTRL: begin
          if (ws[0]) begin
            d.ctrl = wd[cst_pkg::CTRL_W-1:0];
          end
        end
        cst_pkg::OFS_PERIOD: begin
          if (ws[0]) begin
            d.low_period_byte = wd[cst_pkg::LO_LSB +: cst_pkg::BYTE_W];
          end
          if (ws[1]) begin
            d.high_period_byte = wd[cst_pkg::HI_LSB +: cst_pkg::BYTE_W];
          end
        end
        cst_pkg::OFS_COUNT: begin
          d.bresp = cst_pkg::RESP_OKAY;
        end
        cst_pkg::OFS_STATUS: begin
          if (ws[0]) begin
            clr_flag = wd[cst_pkg::STAT_W-1:0];
          end
        end
        cst_pkg::OFS_MASK: begin
          if (ws[0]) begin
            d.mask = wd[cst_pkg::STAT_W-1:0];
          end
        end
        default: begin
          d.bresp = cst_pkg::RESP_SLVERR;
        end
      endcase
    end

    // Read channel: one read at a time, data registered
    case (q.rst)
      cst_pkg::R_IDLE: begin
        if (s_axi_arvalid && q.arready) begin
          d.rst   = cst_pkg::R_DATA;
          d.rdata = '0;
          d.rresp = cst_pkg::RESP_OKAY;
          case (s_axi_araddr)
            cst_pkg::OFS_CTRL:   d.rdata[cst_pkg::CTRL_W-1:0] = q.ctrl;
            cst_pkg::OFS_PERIOD: d.rdata[cst_pkg::HI_LSB+cst_pkg::BYTE_W-1:0] = period16;
            cst_pkg::OFS_COUNT:  d.rdata[cst_pkg::HI_LSB+cst_pkg::BYTE_W-1:0] = count16;
            cst_pkg::OFS_STATUS: d.rdata[cst_pkg::STAT_W-1:0] = q.status;
            cst_pkg::OFS_MASK:   d.rdata[cst_pkg::STAT_W-1:0] = q.mask;
            default:             d.rresp = cst_pkg::RESP_SLVERR;
          endcase
        end
      end
      cst_pkg::R_DATA: begin
        if (s_axi_rready) begin
          d.rst = cst_pkg::R_IDLE;
        end
      end
      default: begin
        d.rst = cst_pkg::R_IDLE;
      end
    endcase

    // Counters
    if (cascade_mode_select) begin
      if (low_counter_enable && high_counter_enable) begin
        if (tick_lo) begin
          if (count16 == period16) begin
            d.low_count_byte  = cst_pkg::CNT_RST;
            d.high_count_byte = cst_pkg::CNT_RST;
            set_flag[cst_pkg::STAT_LOW] = 1'b1;
          end else begin
            {d.high_count_byte, d.low_count_byte} = count16 + 16'h0001;
          end
        end
      end else if (low_counter_enable) begin
        // Only the low byte runs, against the low period byte
        if (tick_lo) begin
          if (q.low_count_byte == q.low_period_byte) begin
            d.low_count_byte = cst_pkg::CNT_RST;
            set_flag[cst_pkg::STAT_LOW] = 1'b1;
          end else begin
            d.low_count_byte = q.low_count_byte + 8'h01;
          end
        end
      end
    end else begin
      // Two independent 8-bit timers, each with its own clock and flag
      if (low_counter_enable && tick_lo) begin
        if (q.low_count_byte == q.low_period_byte) begin
          d.low_count_byte = cst_pkg::CNT_RST;
          set_flag[cst_pkg::STAT_LOW] = 1'b1;
        end else begin
          d.low_count_byte = q.low_count_byte + 8'h01;
        end
      end
      if (high_counter_enable && tick_hi) begin
        if (q.high_count_byte == q.high_period_byte) begin
          d.high_count_byte = cst_pkg::CNT_RST;
          set_flag[cst_pkg::STAT_HIGH] = 1'b1;
        end else begin
          d.high_count_byte = q.high_count_byte + 8'h01;
        end
      end
    end

    // Sticky flags: a set in the clearing cycle wins
    d.status = (q.status & ~clr_flag) | set_flag;
    d.irq    = |(d.status & d.mask);

    // Handshake outputs follow the next state so they leave flops
    d.awready = (d.wst == cst_pkg::W_IDLE) || (d.wst == cst_pkg::W_DATA);
    d.wready  = (d.wst == cst_pkg::W_IDLE) || (d.wst == cst_pkg::W_ADDR);
    d.bvalid  = (d.wst == cst_pkg::W_RESP);
    d.arready = (d.rst == cst_pkg::R_IDLE);
    d.rvalid  = (d.rst == cst_pkg::R_DATA);
  end

  // ==========================================================================
  // State register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q                  <= '0;
      q.ctrl             <= cst_pkg::CTRL_RST;
      q.low_period_byte  <= cst_pkg::PRD_RST;
      q.high_period_byte <= cst_pkg::PRD_RST;
      q.low_count_byte   <= cst_pkg::CNT_RST;
      q.high_count_byte  <= cst_pkg::CNT_RST;
      q.status           <= cst_pkg::STAT_RST;
      q.mask             <= cst_pkg::MASK_RST;
    end else begin
      q <= d;
    end
  end

  // Outputs straight from the state register
  assign s_axi_awready = q.awready;
  assign s_axi_wready  = q.wready;
  assign s_axi_bvalid  = q.bvalid;
  assign s_axi_bresp   = q.bresp;
  assign s_axi_arready = q.arready;
  assign s_axi_rvalid  = q.rvalid;
  assign s_axi_rresp   = q.rresp;
  assign s_axi_rdata   = q.rdata;
  assign irq           = q.irq;

  // ==========================================================================
  // Checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_cascade_step: assert property (
    cascade_mode_select && low_counter_enable && high_counter_enable && tick_lo
    && count16 != period16
    |=> {q.high_count_byte, q.low_count_byte} == $past(count16) + 16'h0001)
    else $error("16-bit count did not step by one");

  a_match_clears: assert property (
    cascade_mode_select && low_counter_enable && high_counter_enable && tick_lo
    && count16 == period16
    |=> count16 == 16'h0000 && q.status[cst_pkg::STAT_LOW])
    else $error("period match did not clear count and set flag");

  a_no_early_clear: assert property (
    cascade_mode_select && low_counter_enable && high_counter_enable
    && count16 != period16 |=> q.status[cst_pkg::STAT_LOW] == $past(q.status[cst_pkg::STAT_LOW])
    || $past(clr_flag[cst_pkg::STAT_LOW]))
    else $error("match flag set before the period was reached");

  a_high_sel_ignored: assert property (
    cascade_mode_select && low_counter_enable && high_counter_enable
    && low_clock_source_select && !ext_fall |=> $stable(count16))
    else $error("16-bit count moved without a low-source tick");

  a_icyc_rate: assert property (
    tick_icyc |=> !tick_icyc [*3] ##1 tick_icyc)
    else $error("instruction cycle is not four clocks");

  a_ext_counts: assert property (
    cascade_mode_select && low_counter_enable && high_counter_enable
    && low_clock_source_select && ext_fall && count16 != period16
    |=> count16 != $past(count16))
    else $error("external falling edge did not advance the count");

  a_low_only: assert property (
    cascade_mode_select && low_counter_enable && !high_counter_enable
    |=> $stable(q.high_count_byte))
    else $error("high byte moved with only the low enable set");

  a_stopped: assert property (
    cascade_mode_select && !low_counter_enable |=> $stable(count16))
    else $error("timer moved with the low enable clear");

  a_indep_high: assert property (
    !cascade_mode_select && high_counter_enable && tick_hi
    && q.high_count_byte != q.high_period_byte
    |=> q.high_count_byte == $past(q.high_count_byte) + 8'h01)
    else $error("independent high timer did not step");

  a_carry_now: assert property (
    cascade_mode_select && low_counter_enable && high_counter_enable && tick_lo
    && q.low_count_byte == 8'hFF && count16 != period16
    |=> q.low_count_byte == 8'h00 && q.high_count_byte == $past(q.high_count_byte) + 8'h01)
    else $error("low rollover did not carry into the high byte");

  a_ext_lag: assert property (
    ext_fall |-> !$past(shared_ext_timer_clock, 3) && $past(shared_ext_timer_clock, 5))
    else $error("edge pulse without an earlier high pin level");

  c_match16:  cover property (cascade_mode_select && set_flag[cst_pkg::STAT_LOW] && high_counter_enable);
  c_ext_tick: cover property (low_clock_source_select && ext_fall && cascade_mode_select);
  c_indep:    cover property (!cascade_mode_select && set_flag == 2'h3);
  c_irq:      cover property ($rose(q.irq));

endmodule // cst_timer

// [cst_ext_src.sv]
`timescale 1ns/1ps

// ============================================================================
// External timer clock source, idles high between bursts
module cst_ext_src #(
  parameter int unsigned HALF = 8  // Clocks per level, above the two needed
) (
  // Clock
  input  wire logic aclk,
  // Timer pin
  output logic      pin
);
  initial pin = 1'b1;

  // Burst of n falling edges; each level is held long enough that the
  // twice-per-cycle sampler cannot miss it
  task automatic burst(input int n);
    repeat (n) begin
      @(posedge aclk) pin <= 1'b0;
      repeat (HALF) @(posedge aclk);
      pin <= 1'b1;
      repeat (HALF) @(posedge aclk);
    end
  endtask
endmodule // cst_ext_src

// [cst_tb.sv]
`timescale 1ns/1ps

module testbench;
  // ==========================================================================
  // Control word bits and test period
  localparam logic [31:0] CAS = 32'h1 << cst_pkg::CTRL_CASCADE;
  localparam logic [31:0] LCS = 32'h1 << cst_pkg::CTRL_LOW_CS;
  localparam logic [31:0] HCS = 32'h1 << cst_pkg::CTRL_HIGH_CS;
  localparam logic [31:0] LEN = 32'h1 << cst_pkg::CTRL_LOW_EN;
  localparam logic [31:0] HEN = 32'h1 << cst_pkg::CTRL_HIGH_EN;
  localparam logic [31:0] PRD = 32'h0000_0102;
  localparam logic [1:0]  OK  = cst_pkg::RESP_OKAY;
  localparam logic [1:0]  ERR = cst_pkg::RESP_SLVERR;

  // Bench signals
  logic        aclk, aresetn, ext_pin, irq;
  logic [5:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, v, c0;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  int          miscompares, n_compared;
  longint      cyc, t1, t2;
  logic [5:0]  ofs [5] = '{cst_pkg::OFS_CTRL, cst_pkg::OFS_PERIOD, cst_pkg::OFS_COUNT,
                           cst_pkg::OFS_STATUS, cst_pkg::OFS_MASK};
  logic [31:0] rst [5] = '{32'h0, 32'h0000_FFFF, 32'h0, 32'h0, 32'h0};

  // ==========================================================================
  // Device and pin source
  cst_timer dut (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .shared_ext_timer_clock(ext_pin), .irq(irq)
  );

  cst_ext_src ext (.aclk(aclk), .pin(ext_pin));

  // Clock and cycle counter for interval measurement
  always #4 aclk = ~aclk;
  always @(posedge aclk) cyc <= cyc + 1;

  // ==========================================================================
  // Compare and bus tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Address and data offered together, each dropped once taken
  task automatic wr(input logic [5:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    forever begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    bready <= 1'b0;
    chk({30'h0, bresp}, {30'h0, er});
  endtask

  task automatic rd(input logic [5:0] a, output logic [31:0] d, input logic [1:0] er);
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    forever begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    d = rdata;
    rready <= 1'b0;
    chk({30'h0, rresp}, {30'h0, er});
  endtask

  task automatic rd_chk(input logic [5:0] a, input logic [31:0] exp);
    rd(a, v, OK);
    chk(v, exp);
  endtask

  // Looks at irq once the edge's updates have landed
  task automatic irq_is(input logic e);
    #1;
    chk({31'h0, irq}, {31'h0, e});
  endtask

  task automatic wait_irq(output longint t);
    repeat (3000) begin
      @(posedge aclk);
      #1;
      if (irq === 1'b1) break;
    end
    t = cyc;
    chk({31'h0, irq}, 32'h1);
  endtask

  task automatic tally_and_finish();
    if (miscompares == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // ==========================================================================
  // Test sequence
  initial begin
    {aclk, aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata} = '0;
    wstrb = 4'hF;
    cyc = 0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    // Reset values, refused addresses, read-only count
    foreach (ofs[i]) rd_chk(ofs[i], rst[i]);
    wr(6'h14, 32'h1, ERR);
    rd(6'h3C, v, ERR);
    chk(v, 32'h0);
    wr(cst_pkg::OFS_COUNT, 32'h1234, OK);
    rd_chk(cst_pkg::OFS_COUNT, 32'h0);
    // Internal clock, high select set but must be ignored: match interval
    wr(cst_pkg::OFS_MASK, 32'h1, OK);
    wr(cst_pkg::OFS_PERIOD, PRD, OK);
    wr(cst_pkg::OFS_CTRL, CAS | HCS | LEN | HEN, OK);
    wait_irq(t1);
    wr(cst_pkg::OFS_STATUS, 32'h1, OK);
    irq_is(1'b0);
    wait_irq(t2);
    chk(32'(t2 - t1), 32'((PRD + 32'h1) * cst_pkg::INSTR_DIV));
    wr(cst_pkg::OFS_CTRL, 32'h0, OK);
    wr(cst_pkg::OFS_STATUS, 32'h1, OK);
    irq_is(1'b0);
    // External pin, full 16-bit count across a low byte rollover
    wr(cst_pkg::OFS_PERIOD, 32'h0000_FFFF, OK);
    rd(cst_pkg::OFS_COUNT, c0, OK);
    wr(cst_pkg::OFS_CTRL, CAS | LCS | LEN | HEN, OK);
    ext.burst(300);
    wr(cst_pkg::OFS_CTRL, 32'h0, OK);
    c0 = c0 + 32'd300;
    rd_chk(cst_pkg::OFS_COUNT, c0);
    // Cascade with low enable only: low byte alone counts and matches
    wr(cst_pkg::OFS_CTRL, CAS | LCS | LEN, OK);
    ext.burst(300);
    wr(cst_pkg::OFS_CTRL, 32'h0, OK);
    c0 = {c0[31:8], 8'(c0[7:0] + 8'd44)};
    rd_chk(cst_pkg::OFS_COUNT, c0);
    rd_chk(cst_pkg::OFS_STATUS, 32'h1);
    irq_is(1'b1);
    wr(cst_pkg::OFS_MASK, 32'h0, OK);
    irq_is(1'b0);
    wr(cst_pkg::OFS_STATUS, 32'h1, OK);
    // Cascade with low enable clear: nothing moves
    wr(cst_pkg::OFS_CTRL, CAS | LCS | HEN, OK);
    ext.burst(50);
    wr(cst_pkg::OFS_CTRL, 32'h0, OK);
    rd_chk(cst_pkg::OFS_COUNT, c0);
    // Two independent 8-bit timers, no carry between them
    wr(cst_pkg::OFS_CTRL, LCS | HCS | LEN | HEN, OK);
    ext.burst(50);
    wr(cst_pkg::OFS_CTRL, 32'h0, OK);
    c0 = {c0[31:16], 8'(c0[15:8] + 8'd50), 8'(c0[7:0] + 8'd50)};
    rd_chk(cst_pkg::OFS_COUNT, c0);
    // Period equal to the count: both 8-bit timers match on the next internal tick
    wr(cst_pkg::OFS_PERIOD, c0, OK);
    wr(cst_pkg::OFS_MASK, 32'h2, OK);
    wr(cst_pkg::OFS_CTRL, LEN | HEN, OK);
    repeat (8) @(posedge aclk);
    wr(cst_pkg::OFS_CTRL, 32'h0, OK);
    rd_chk(cst_pkg::OFS_STATUS, 32'h3);
    irq_is(1'b1);
    wr(cst_pkg::OFS_STATUS, 32'h3, OK);
    irq_is(1'b0);
    tally_and_finish();
  end

  // Watchdog well beyond the roughly 15000 cycles the tests need
  initial begin
    repeat (40000) @(posedge aclk);
    miscompares++;
    tally_and_finish();
  end
endmodule // testbench
